// [twm_master.sv]
/*
 twm_master: two-wire master transmitter behind an APB slave.
 Assumes open-drain scl/sda with external pull-ups; the testbench
 resolves each wire from the enables.
*/
// What this block does
// - Four bus modes exist; only master transmit is built, mode is shown.
// - Master work starts after START; address read bit picks receive mode.
// - START waits until the bus is seen free, never forced.
// - After START goes out, done flag sets and status reads 0x08.
// - After address and ack, done sets with status 0x18, 0x20 or 0x38.
// - Data writes while done is low are dropped and set write collision.
// - Start request with stop zero sends repeated START, status 0x10.
// - Repeated START keeps bus ownership between transfers.
// - Prescaler bits sit in status low bits; software masks with 0xF8.
// - Bus transfer is suspended while done flag is set.
// - Done is set by hardware; write one clears, write zero keeps.
// - While done is set the clock line is held low, except after lost arbitration.
// - A transmitted STOP does not set the done flag.
// - The stop request clears itself when STOP is sent.
// - Lost arbitration reports 0x38, frees the bus, restarts when asked.
`timescale 1ns/1ps
module twm_master
   import twm_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              scl_i,
   output logic                   scl_o,
   output logic                   scl_oe_n,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_n
);

   ////////////////////////////////////////////////////////////////////
   // types and state

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_WAIT  = 6'b000010,
      ST_START = 6'b000100,
      ST_HOLD  = 6'b001000,
      ST_BIT   = 6'b010000,
      ST_STOP  = 6'b100000
   } twm_state_t;

   twm_state_t state_q;
   twm_state_t state_d;

   logic       done_q;
   logic       acken_q;
   logic       sta_q;
   logic       sto_q;
   logic       wc_q;
   logic       en_q;
   logic       irqen_q;
   logic [1:0] ps_q;
   logic [7:0] data_q;
   logic [7:0] stat_q;
   logic [7:0] stat_d;
   logic [1:0] mode_q;
   logic [1:0] mode_d;
   logic [1:0] ph_q;
   logic [1:0] ph_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic       first_q;
   logic       first_d;
   logic       rep_q;
   logic       rep_d;
   logic       own_q;
   logic       own_d;
   logic       scl_low_q;
   logic       scl_low_d;
   logic       sda_low_q;
   logic       sda_low_d;
   logic       busy_q;
   logic       sda_p_q;
   logic       hw_set;
   logic       hw_sto_clr;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and bus-free watch

   logic [1:0] pin_raw;
   logic [1:0] pin_f;
   logic       scl_f;
   logic       sda_f;

   assign pin_raw = {scl_i, sda_i};
   assign scl_f   = pin_f[1];
   assign sda_f   = pin_f[0];

   for (genvar g = 0; g < 2; g++) begin : g_sync
      twm_sync u_sync (
         .clk   (pclk),
         .rst_n (presetn),
         .din   (pin_raw[g]),
         .dout  (pin_f[g])
      );
   end

   wire start_seen = scl_f && sda_p_q && !sda_f;
   wire stop_seen  = scl_f && !sda_p_q && sda_f;

   // busy tracks any master's START..STOP, ours included
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_p_q <= 1'b1;
         busy_q  <= 1'b0;
      end else begin
         sda_p_q <= sda_f;
         if (start_seen) begin
            busy_q <= 1'b1;
         end else if (stop_seen) begin
            busy_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // quarter-bit ticks; stopped while suspended so phases restart clean

   logic tick;
   wire  div_run = en_q && (state_q inside {ST_START, ST_BIT, ST_STOP});

   twm_div u_div (
      .clk   (pclk),
      .rst_n (presetn),
      .run   (div_run),
      .ps    (ps_q),
      .tick  (tick)
   );

   // phase 2 waits for scl really high, so a slave may stretch
   wire adv = tick && !((ph_q == 2'h2) && !scl_f);

   ////////////////////////////////////////////////////////////////////
   // APB decode

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        off);
      return a == off;
   endfunction : hit

   function automatic logic [7:0] byte_stat(input logic adr,
                                            input logic nak);
      if (adr) begin
         return nak ? STAT_ADR_NAK : STAT_ADR_ACK;
      end
      return nak ? STAT_DAT_NAK : STAT_DAT_ACK;
   endfunction : byte_stat

   wire acc     = psel && penable;
   wire setup   = psel && !penable;
   wire mapped  = hit(paddr, OFF_CTRL) || hit(paddr, OFF_STAT) ||
                  hit(paddr, OFF_DATA) || hit(paddr, OFF_MODE);
   wire wr_ctrl = acc && pwrite && hit(paddr, OFF_CTRL);
   wire wr_stat = acc && pwrite && hit(paddr, OFF_STAT);
   wire wr_data = acc && pwrite && hit(paddr, OFF_DATA);

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   wire [7:0] ctrl_rd = {done_q, acken_q, sta_q, sto_q,
                         wc_q, en_q, 1'b0, irqen_q};
   wire [7:0] stat_rd = {stat_q[7:3], 1'b0, ps_q};
   wire [7:0] rd_mux  = hit(paddr, OFF_CTRL) ? ctrl_rd :
                        hit(paddr, OFF_STAT) ? stat_rd :
                        hit(paddr, OFF_DATA) ? data_q  :
                        hit(paddr, OFF_MODE) ? {6'h00, mode_q} : 8'h00;

   // read data is captured in the setup cycle, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata <= {24'h000000, rd_mux};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers written by software

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acken_q <= 1'b0;
         sta_q   <= 1'b0;
         en_q    <= 1'b0;
         irqen_q <= 1'b0;
         ps_q    <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            acken_q <= pwdata[B_ACKEN];
            sta_q   <= pwdata[B_STA];
            en_q    <= pwdata[B_EN];
            irqen_q <= pwdata[B_IRQEN];
         end
         if (wr_stat) begin
            ps_q <= pwdata[1:0];
         end
      end
   end

   // hardware set wins over a same-cycle write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
      end else if (hw_set) begin
         done_q <= 1'b1;
      end else if (wr_ctrl && pwdata[B_DONE]) begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sto_q <= 1'b0;
      end else if (wr_ctrl) begin
         sto_q <= pwdata[B_STO];
      end else if (hw_sto_clr) begin
         sto_q <= 1'b0;
      end
   end

   // a data write lands only while suspended
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_q <= DATA_RST;
         wc_q   <= 1'b0;
      end else if (wr_data) begin
         if (done_q) begin
            data_q <= pwdata[7:0];
            wc_q   <= 1'b0;
         end else begin
            wc_q   <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus sequencer

   wire tx_bit = (bit_q == ACK_BIT) ? 1'b1 : data_q[3'(4'h7 - bit_q)];

   always_comb begin
      state_d    = state_q;
      ph_d       = ph_q;
      bit_d      = bit_q;
      first_d    = first_q;
      rep_d      = rep_q;
      own_d      = own_q;
      stat_d     = stat_q;
      mode_d     = mode_q;
      scl_low_d  = scl_low_q;
      sda_low_d  = sda_low_q;
      hw_set     = 1'b0;
      hw_sto_clr = 1'b0;
      if (!en_q) begin
         state_d   = ST_IDLE;
         own_d     = 1'b0;
         mode_d    = MODE_IDLE;
         scl_low_d = 1'b0;
         sda_low_d = 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (!done_q && sta_q) begin
                  state_d = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!busy_q) begin
                  state_d = ST_START;
                  ph_d    = 2'h0;
                  rep_d   = 1'b0;
               end
            end
            ST_START: begin
               if (adv) begin
                  ph_d = ph_q + 2'h1;
                  case (ph_q)
                     2'h0: sda_low_d = 1'b0;
                     2'h1: scl_low_d = 1'b0;
                     2'h2: sda_low_d = 1'b1;
                     default: begin
                        scl_low_d = 1'b1;
                        state_d   = ST_HOLD;
                        hw_set    = 1'b1;
                        own_d     = 1'b1;
                        first_d   = 1'b1;
                        stat_d    = rep_q ? STAT_RSTART
                                          : STAT_START;
                     end
                  endcase
               end
            end
            ST_HOLD: begin
               scl_low_d = 1'b1;
               ph_d      = 2'h0;
               bit_d     = 4'h0;
               if (!done_q) begin
                  if (sto_q) begin
                     state_d = ST_STOP;
                  end else if (sta_q) begin
                     state_d = ST_START;
                     rep_d   = 1'b1;
                  end else begin
                     state_d = ST_BIT;
                  end
               end
            end
            ST_BIT: begin
               if (adv) begin
                  ph_d = ph_q + 2'h1;
                  case (ph_q)
                     2'h0: sda_low_d = !tx_bit;
                     2'h1: scl_low_d = 1'b0;
                     2'h2: begin
                        if (bit_q != ACK_BIT && tx_bit && !sda_f) begin
                           state_d   = ST_IDLE;
                           stat_d    = STAT_LOST;
                           hw_set    = 1'b1;
                           own_d     = 1'b0;
                           mode_d    = MODE_IDLE;
                           sda_low_d = 1'b0;
                        end else if (bit_q == ACK_BIT) begin
                           stat_d = byte_stat(first_q, sda_f);
                        end
                        if (first_q && bit_q == 4'h7) begin
                           mode_d = tx_bit ? MODE_MR : MODE_MT;
                        end
                     end
                     default: begin
                        scl_low_d = 1'b1;
                        if (bit_q == ACK_BIT) begin
                           state_d = ST_HOLD;
                           hw_set  = 1'b1;
                           first_d = 1'b0;
                        end else begin
                           bit_d = bit_q + 4'h1;
                        end
                     end
                  endcase
               end
            end
            ST_STOP: begin
               if (adv) begin
                  ph_d = ph_q + 2'h1;
                  case (ph_q)
                     2'h0: sda_low_d = 1'b1;
                     2'h1: scl_low_d = 1'b0;
                     2'h2: sda_low_d = 1'b0;
                     default: begin
                        // no done flag after STOP
                        state_d    = sta_q ? ST_WAIT : ST_IDLE;
                        hw_sto_clr = 1'b1;
                        own_d      = 1'b0;
                        mode_d     = MODE_IDLE;
                        stat_d     = STAT_IDLE;
                     end
                  endcase
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= ST_IDLE;
         ph_q      <= 2'h0;
         bit_q     <= 4'h0;
         first_q   <= 1'b0;
         rep_q     <= 1'b0;
         own_q     <= 1'b0;
         stat_q    <= STAT_IDLE;
         mode_q    <= MODE_IDLE;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         ph_q      <= ph_d;
         bit_q     <= bit_d;
         first_q   <= first_d;
         rep_q     <= rep_d;
         own_q     <= own_d;
         stat_q    <= stat_d;
         mode_q    <= mode_d;
         scl_low_q <= scl_low_d;
         sda_low_q <= sda_low_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // open-drain pins: enable low means pulling the wire low

   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe_n = !scl_low_q;
   assign sda_oe_n = !sda_low_q;

endmodule : twm_master

// [twm_pkg.sv]
/*
 twm_pkg: constants shared by the two-wire master-transmit block.
 Assumes a 10 MHz pclk and APB access with 32-bit aligned registers.
*/
package twm_pkg;

   // register byte offsets
   localparam int unsigned ADDR_W   = 8;
   localparam logic [7:0]  OFF_CTRL = 8'h00;
   localparam logic [7:0]  OFF_STAT = 8'h04;
   localparam logic [7:0]  OFF_DATA = 8'h08;
   localparam logic [7:0]  OFF_MODE = 8'h0C;

   // bus_control field positions
   localparam int unsigned B_DONE  = 7;
   localparam int unsigned B_ACKEN = 6;
   localparam int unsigned B_STA   = 5;
   localparam int unsigned B_STO   = 4;
   localparam int unsigned B_WC    = 3;
   localparam int unsigned B_EN    = 2;
   localparam int unsigned B_IRQEN = 0;

   // status_reg layout and codes
   localparam logic [7:0] STAT_MASK    = 8'hF8;
   localparam logic [7:0] STAT_IDLE    = 8'hF8;
   localparam logic [7:0] STAT_START   = 8'h08;
   localparam logic [7:0] STAT_RSTART  = 8'h10;
   localparam logic [7:0] STAT_ADR_ACK = 8'h18;
   localparam logic [7:0] STAT_ADR_NAK = 8'h20;
   localparam logic [7:0] STAT_DAT_ACK = 8'h28;
   localparam logic [7:0] STAT_DAT_NAK = 8'h30;
   localparam logic [7:0] STAT_LOST    = 8'h38;
   localparam logic [7:0] DATA_RST     = 8'hFF;

   // bus mode shown in the mode register
   localparam logic [1:0] MODE_IDLE = 2'h0;
   localparam logic [1:0] MODE_MT   = 2'h1;
   localparam logic [1:0] MODE_MR   = 2'h2;

   // timing: one bit is four quarter ticks
   localparam int unsigned CLK_NS  = 100;
   localparam int unsigned QTR_NS  = 200;
   localparam int unsigned QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned DIV_W   = 8;
   localparam logic [3:0]  ACK_BIT = 4'h8;

endpackage : twm_pkg

// [twm_sync.sv]
/*
 twm_sync: three-flop input synchroniser with agreement filter.
 Assumes an asynchronous input whose idle level is high.
*/
`timescale 1ns/1ps
module twm_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // s1 feeds only s2; a change counts once s2 and s3 agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            dout <= s3_q;
         end
      end
   end
endmodule : twm_sync

// [twm_div.sv]
/*
 twm_div: quarter-bit tick divider with a prescaler select.
 Assumes run is low between bus phases so ticks restart aligned.
*/
`timescale 1ns/1ps
module twm_div
   import twm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [1:0] ps,
   output logic            tick
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] reload;

   // prescaler multiplies the quarter period by 1, 4, 16 or 64
   assign reload = DIV_W'((QTR_CYC << {ps, 1'b0}) - 1);
   assign tick   = run && (cnt_q == '0);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (!run) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= reload;
      end else begin
         cnt_q <= cnt_q - DIV_W'(1);
      end
   end
endmodule : twm_div

// [twm_master_props.sv]
/*
 twm_master_props: port-level assertions for twm_master.
 Assumes the bind below and open-drain pins resolved outside.
*/
`timescale 1ns/1ps
module twm_master_props
   import twm_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              scl_i,
   input wire logic              scl_o,
   input wire logic              scl_oe_n,
   input wire logic              sda_i,
   input wire logic              sda_o,
   input wire logic              sda_oe_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   wire logic acc = psel && penable;
   wire logic hit = (paddr == OFF_CTRL) || (paddr == OFF_STAT) ||
                    (paddr == OFF_DATA) || (paddr == OFF_MODE);

   // sda falls while scl is released: a start or repeated start
   sequence s_start;
      $fell(sda_oe_n) && scl_oe_n;
   endsequence
   // sda released while scl is released: a stop
   sequence s_stop;
      $rose(sda_oe_n) && scl_oe_n;
   endsequence

   ////////////////////////////////////////////////////////////////////
   a_ready_high: assert property (pready)
      else $error("pready not high");
   a_err_unmapped: assert property (acc && !hit |-> pslverr)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (acc && hit |-> !pslverr)
      else $error("error on mapped access");
   a_read_unmapped: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_pins_low: assert property (!scl_o && !sda_o)
      else $error("pin output value not zero");
   a_start_form: assert property (s_start |-> ##[1:16] !scl_oe_n)
      else $error("start not followed by clock low");
   a_stop_form: assert property (s_stop |-> scl_oe_n [*2])
      else $error("clock pulled right after stop");
   a_scl_low_min: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*3])
      else $error("clock low phase too short");
   a_scl_high_min: assert property ($rose(scl_oe_n) |-> scl_oe_n [*3])
      else $error("clock high phase too short");
endmodule : twm_master_props

bind twm_master twm_master_props i_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

// [twm_slave.sv]
/*
 twm_slave: behavioural slave receiver on the two-wire bus.
 Assumes resolved wires with pull-ups; pulls are active high.
*/
`timescale 1ns/1ps
module twm_slave (
   input  wire logic  scl,
   input  wire logic  sda,
   input  wire logic  ack_en,
   input  wire logic  lose,
   input  wire logic  stretch,
   output logic       sda_pull,
   output logic       scl_pull,
   output logic [7:0] last_byte,
   output int         n_starts,
   output int         n_stops
);
   logic [7:0] sh;
   int         bits;
   logic       armed;

   initial begin
      sda_pull = 1'b0;
      scl_pull = 1'b0;
      armed = 1'b0;
      bits = 0;
   end
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         n_starts++;
         bits = 0;
         armed = lose;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         n_stops++;
      end
   end
   always @(posedge scl) begin
      if (bits < 8) begin
         sh = {sh[6:0], sda};
      end
      bits++;
   end
   // an armed slave plays a rival master holding sda low
   always @(negedge scl) begin
      if (armed) begin
         sda_pull = 1'b1;
      end else if (bits == 8) begin
         sda_pull = ack_en;
         last_byte = sh;
      end else if (bits == 9) begin
         sda_pull = 1'b0;
         bits = 0;
         if (stretch) begin
            scl_pull = 1'b1;
            #2000;
            scl_pull = 1'b0;
         end
      end
   end
   always @(negedge lose) begin
      armed = 1'b0;
      sda_pull = 1'b0;
   end
endmodule : twm_slave

// [tb_top.sv]
/*
 tb_top: self-checking bench for twm_master with a slave model.
 Assumes a 10 MHz pclk and pull-ups on both bus wires.
*/
`timescale 1ns/1ps
module tb_top;
   import twm_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n;
   logic        ack_en = 1'b1;
   logic        lose = 1'b0;
   logic        stretch = 1'b0;
   logic        sda_pull, scl_pull;
   logic [7:0]  last_byte;
   int          n_starts, n_stops;
   int          errors = 0;
   int          n_compared = 0;
   int          cyc = 0;
   wire logic   scl_w = (scl_oe_n ? 1'b1 : scl_o) & ~scl_pull;
   wire logic   sda_w = (sda_oe_n ? 1'b1 : sda_o) & ~sda_pull;

   always #50 pclk = ~pclk;

   twm_master i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n));
   twm_slave i_slave (.scl(scl_w), .sda(sda_w), .ack_en(ack_en),
      .lose(lose), .stretch(stretch), .sda_pull(sda_pull),
      .scl_pull(scl_pull), .last_byte(last_byte), .n_starts(n_starts),
      .n_stops(n_stops));

   ////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, d,
                      output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 8'h00, q, e);
      chk(q, exp, what);
   endtask : rd_chk

   // software polls the flag, as there is no interrupt line
   task automatic wait_done;
      logic [31:0] q;
      logic        e;
      int          n;
      n = 0;
      q = 32'h0;
      while (q[B_DONE] !== 1'b1 && n < 400) begin
         apb(1'b0, OFF_CTRL, 8'h00, q, e);
         n++;
      end
      chk({31'h0, q[B_DONE]}, 32'h1, "done flag");
   endtask : wait_done

   ////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] q;
      logic        e;
      rd_chk(OFF_CTRL, 32'h0, "ctrl reset");
      rd_chk(OFF_STAT, 32'hF8, "status reset");
      rd_chk(OFF_DATA, 32'hFF, "data reset");
      rd_chk(OFF_MODE, 32'h0, "mode reset");
      wr(OFF_CTRL, 8'h02);
      rd_chk(OFF_CTRL, 32'h0, "unused bit");
      wr(OFF_STAT, 8'h03);
      rd_chk(OFF_STAT, 32'hFB, "prescaler bits");
      wr(OFF_STAT, 8'h00);
      apb(1'b0, 8'h10, 8'h00, q, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      chk(q, 32'h0, "unmapped data");
   endtask : t_regs

   task automatic t_collide;
      wr(OFF_DATA, 8'h5A);
      rd_chk(OFF_DATA, 32'hFF, "dropped data");
      rd_chk(OFF_CTRL, 32'h08, "collision flag");
   endtask : t_collide

   task automatic t_frame;
      logic [31:0] q;
      logic        e;
      int          s0;
      s0 = n_stops;
      wr(OFF_CTRL, 8'hA4);
      wait_done;
      rd_chk(OFF_STAT, 32'h08, "start status");
      repeat (40) @(posedge pclk);
      chk({31'h0, scl_oe_n}, 32'h0, "clock held");
      wr(OFF_DATA, 8'hA0);
      apb(1'b0, OFF_CTRL, 8'h00, q, e);
      chk({31'h0, q[B_WC]}, 32'h0, "collision cleared");
      wr(OFF_CTRL, 8'h24);
      rd_chk(OFF_CTRL, 32'hA4, "write zero keeps done");
      wr(OFF_CTRL, 8'h84);
      wait_done;
      rd_chk(OFF_STAT, 32'h18, "address acked");
      rd_chk(OFF_MODE, 32'h1, "transmit mode");
      chk({24'h0, last_byte}, 32'hA0, "address byte");
      stretch <= 1'b1;
      wr(OFF_DATA, 8'h3C);
      wr(OFF_CTRL, 8'h84);
      wait_done;
      stretch <= 1'b0;
      rd_chk(OFF_STAT, 32'h28, "data acked");
      chk({24'h0, last_byte}, 32'h3C, "data byte");
      wr(OFF_CTRL, 8'hA4);
      wait_done;
      rd_chk(OFF_STAT, 32'h10, "repeated start");
      chk(32'(n_stops), 32'(s0), "bus kept");
      ack_en <= 1'b0;
      wr(OFF_DATA, 8'hA0);
      wr(OFF_CTRL, 8'h84);
      wait_done;
      rd_chk(OFF_STAT, 32'h20, "address nacked");
      ack_en <= 1'b1;
      wr(OFF_CTRL, 8'h94);
      repeat (200) @(posedge pclk);
      rd_chk(OFF_CTRL, 32'h04, "no done, stop cleared");
      rd_chk(OFF_STAT, 32'hF8, "idle status");
      chk(32'(n_stops), 32'(s0 + 1), "stop on wire");
   endtask : t_frame

   task automatic t_lost;
      int s0;
      lose <= 1'b1;
      wr(OFF_CTRL, 8'hA4);
      wait_done;
      wr(OFF_DATA, 8'hA0);
      wr(OFF_CTRL, 8'h84);
      wait_done;
      rd_chk(OFF_STAT, 32'h38, "arbitration lost");
      chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3, "bus released");
      s0 = n_starts;
      wr(OFF_CTRL, 8'hA4);
      repeat (100) @(posedge pclk);
      rd_chk(OFF_CTRL, 32'h24, "waits for free bus");
      chk(32'(n_starts), 32'(s0), "no forced start");
      lose <= 1'b0;
      wait_done;
      rd_chk(OFF_STAT, 32'h08, "start when free");
      wr(OFF_CTRL, 8'h94);
      repeat (200) @(posedge pclk);
      rd_chk(OFF_STAT, 32'hF8, "idle again");
   endtask : t_lost

   ////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         $display("Error at %0t: run too long", $time);
         close_out();
      end
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_collide();
      t_frame();
      t_lost();
      close_out();
   end
endmodule : tb_top
